// File: design/sleep_wdt.sv
// Sleep controller with watchdog timer for a small core
`timescale 1ns/1ps
// Operation
// - Sleep instruction enters sleep, gates CPU clock
// - Sleep entry clears power-down, sets time-out flag
// - Low-frequency oscillator keeps running
// - Port outputs hold state during sleep
// - Non-watchdog resets work while asleep
// - Resets restart device; other wakes continue
// - Only enabled interrupts wake; global enable ignored
// - Next instruction runs, then ISR if enabled
// - Watchdog cleared on every wake-up
// - Pending enabled interrupt makes sleep no-op
// - Interrupt during sleep: complete, wake, clear
// - Expired watchdog period resets the device
// - Watchdog counts low-frequency oscillator ticks
// - Mode 11: watchdog always active
// - Mode 10: active awake, off asleep
// - Mode 01 software enable; 00 disabled
// - Period 1 ms to 256 s, reset 2 s
// - Watchdog cleared on listed clearing events
// - Watchdog cleared on entry, counts if enabled
// - Sleep time-out wakes instead of resetting
// - Period codes double; reserved codes give minimum
// - Watchdog held clear while start-up timer runs
module sleep_wdt (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Register port
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   // Core events
   input wire logic i_sleep_instr,
   input wire logic i_watchdog_clear_instr,
   input wire logic i_irq_pending,
   input wire logic [1:0] i_watchdog_cfg_mode,
   input wire logic i_lfosc_tick,
   input wire logic i_osc_fail,
   input wire logic i_osc_startup_timer_run,
   // Outputs
   output logic [7:0] o_rdata,
   output logic o_cpu_clk_en,
   output logic o_port_hold,
   output logic o_lfosc_en,
   output logic o_wdt_reset,
   output logic o_wake,
   output logic o_run_isr
);
   sleep_wdt_pkg::core_state_t st_q, st_d;
   logic [7:0] intctl_q, intctl_d;
   logic [4:0] ps_q, ps_d;
   logic swen_q, swen_d;
   logic to_n_q, to_n_d;
   logic pd_n_q, pd_n_d;
   logic [sleep_wdt_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0] rdata_d;
   logic cpu_en_d, hold_d, rst_d, wake_d, isr_d;
   logic asleep, active, expired, clr, global_irq_enable;
   logic [sleep_wdt_pkg::CNT_W-1:0] limit;
   logic [4:0] ps_eff;

   // ----------------------------------------
   // Watchdog mode and period
   // ----------------------------------------
   always_comb begin
      asleep = (st_q == sleep_wdt_pkg::ST_SLEEP);
      global_irq_enable = intctl_q[sleep_wdt_pkg::GIE_BIT];
      unique case (i_watchdog_cfg_mode)
         sleep_wdt_pkg::MODE_ON: active = 1'b1;
         sleep_wdt_pkg::MODE_NOSLEEP: active = !asleep;
         sleep_wdt_pkg::MODE_SW: active = swen_q;
         sleep_wdt_pkg::MODE_OFF: active = 1'b0;
      endcase
      ps_eff = (ps_q > sleep_wdt_pkg::PS_MAX) ? sleep_wdt_pkg::PS_MIN : ps_q;
      // Terminal count 2^(5+ps)-1 ticks
      limit = {sleep_wdt_pkg::CNT_W{1'b1}} >>
         (5'(sleep_wdt_pkg::PS_MAX) - ps_eff);
      expired = active && i_lfosc_tick && (cnt_q == limit);
   end

   // ----------------------------------------
   // Sleep control, flags and counter
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      to_n_d = to_n_q;
      pd_n_d = pd_n_q;
      cpu_en_d = 1'b1;
      wake_d = 1'b0;
      isr_d = 1'b0;
      rst_d = 1'b0;
      clr = i_watchdog_clear_instr || i_osc_fail || !active ||
         i_osc_startup_timer_run;
      unique case (st_q)
         sleep_wdt_pkg::ST_RUN: begin
            if (i_sleep_instr && !i_irq_pending) begin
               st_d = sleep_wdt_pkg::ST_SLEEP;
               pd_n_d = 1'b0;
               to_n_d = 1'b1;
               cpu_en_d = 1'b0;
               clr = 1'b1;
            end else if (i_watchdog_clear_instr) begin
               to_n_d = 1'b1;
               pd_n_d = 1'b1;
            end else if (expired) begin
               rst_d = 1'b1;
               to_n_d = 1'b0;
            end
         end
         sleep_wdt_pkg::ST_SLEEP: begin
            cpu_en_d = 1'b0;
            if (i_irq_pending || expired) begin
               st_d = sleep_wdt_pkg::ST_WAKE;
               cpu_en_d = 1'b1;
               wake_d = 1'b1;
               clr = 1'b1;
               if (expired) begin
                  to_n_d = 1'b0;
               end
            end
         end
         sleep_wdt_pkg::ST_WAKE: begin
            // next instruction then ISR if enabled
            st_d = sleep_wdt_pkg::ST_RUN;
            isr_d = global_irq_enable && i_irq_pending;
         end
         default: st_d = sleep_wdt_pkg::ST_RUN;
      endcase
      hold_d = !cpu_en_d;
      if (clr || expired) begin
         cnt_d = '0;
      end else if (i_lfosc_tick) begin
         cnt_d = cnt_q + 1'b1;
      end else begin
         cnt_d = cnt_q;
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   always_comb begin
      intctl_d = intctl_q;
      ps_d = ps_q;
      swen_d = swen_q;
      rdata_d = 8'h00;
      if (i_wr && i_addr == sleep_wdt_pkg::ADDR_INTCTL) begin
         intctl_d = i_wdata;
      end
      if (i_wr && i_addr == sleep_wdt_pkg::ADDR_WDTCTL) begin
         ps_d = i_wdata[sleep_wdt_pkg::PS_MSB:sleep_wdt_pkg::PS_LSB];
         swen_d = i_wdata[sleep_wdt_pkg::SWEN_BIT];
      end
      if (i_rd) begin
         unique case (i_addr)
            sleep_wdt_pkg::ADDR_INTCTL: rdata_d = intctl_q;
            sleep_wdt_pkg::ADDR_STATUS: begin
               rdata_d[sleep_wdt_pkg::TO_BIT] = to_n_q;
               rdata_d[sleep_wdt_pkg::PD_BIT] = pd_n_q;
            end
            sleep_wdt_pkg::ADDR_WDTCTL: begin
               rdata_d[sleep_wdt_pkg::PS_MSB:sleep_wdt_pkg::PS_LSB] = ps_q;
               rdata_d[sleep_wdt_pkg::SWEN_BIT] = swen_q;
            end
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // external resets arrive on i_arst_n and act in any state
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= sleep_wdt_pkg::ST_RUN;
         intctl_q <= sleep_wdt_pkg::INTCTL_RESET;
         ps_q <= sleep_wdt_pkg::PS_RESET;
         swen_q <= 1'b0;
         to_n_q <= 1'b1;
         pd_n_q <= 1'b1;
         cnt_q <= '0;
         o_rdata <= 8'h00;
         o_cpu_clk_en <= 1'b1;
         o_port_hold <= 1'b0;
         o_lfosc_en <= 1'b1;
         o_wdt_reset <= 1'b0;
         o_wake <= 1'b0;
         o_run_isr <= 1'b0;
      end else begin
         st_q <= st_d;
         intctl_q <= intctl_d;
         ps_q <= ps_d;
         swen_q <= swen_d;
         to_n_q <= to_n_d;
         pd_n_q <= pd_n_d;
         cnt_q <= cnt_d;
         o_rdata <= rdata_d;
         o_cpu_clk_en <= cpu_en_d;
         o_port_hold <= hold_d;
         o_lfosc_en <= 1'b1;
         o_wdt_reset <= rst_d;
         o_wake <= wake_d;
         o_run_isr <= isr_d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_sleep_take;
      i_sleep_instr && !i_irq_pending && st_q == sleep_wdt_pkg::ST_RUN;
   endsequence
   property p_gate;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      s_sleep_take |=> !o_cpu_clk_en && o_port_hold;
   endproperty
   a_gate: assert property (p_gate) else $error("clock not gated");
   property p_flags;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      s_sleep_take |=> !pd_n_q && to_n_q;
   endproperty
   a_flags: assert property (p_flags) else $error("flags wrong");
   property p_nop;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_sleep_instr && i_irq_pending && st_q == sleep_wdt_pkg::ST_RUN
      |=> st_q == sleep_wdt_pkg::ST_RUN && $stable(pd_n_q);
   endproperty
   a_nop: assert property (p_nop) else $error("sleep not a no-op");
   property p_wake;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      asleep && i_irq_pending |=> o_wake && cnt_q == '0 ##1 o_cpu_clk_en;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_nores;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      asleep |=> !o_wdt_reset;
   endproperty
   a_nores: assert property (p_nores) else $error("reset in sleep");
   property p_off;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_watchdog_cfg_mode == sleep_wdt_pkg::MODE_OFF |=> cnt_q == '0;
   endproperty
   a_off: assert property (p_off) else $error("watchdog ran");
   property p_clear;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_watchdog_clear_instr |=> cnt_q == '0 && !o_wdt_reset;
   endproperty
   a_clear: assert property (p_clear) else $error("not cleared");
   property p_ost;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_osc_startup_timer_run |=> cnt_q == '0;
   endproperty
   a_ost: assert property (p_ost) else $error("held count moved");
   property p_lf;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      1'b1 |=> o_lfosc_en;
   endproperty
   a_lf: assert property (p_lf) else $error("osc off");
   property p_hold;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      1'b1 |-> o_port_hold != o_cpu_clk_en;
   endproperty
   a_hold: assert property (p_hold) else $error("hold wrong");
   property p_stay;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      asleep && !i_irq_pending && !expired |=> asleep && !o_cpu_clk_en;
   endproperty
   a_stay: assert property (p_stay) else $error("left sleep");
   property p_twake;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      asleep && expired |=> o_wake && !to_n_q && !pd_n_q;
   endproperty
   a_twake: assert property (p_twake) else $error("bad timed wake");
   property p_exp;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_q == sleep_wdt_pkg::ST_RUN && expired && !i_sleep_instr &&
      !i_watchdog_clear_instr |=> o_wdt_reset && !to_n_q;
   endproperty
   a_exp: assert property (p_exp) else $error("no reset");
   property p_isr;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_q == sleep_wdt_pkg::ST_WAKE && global_irq_enable && i_irq_pending |=> o_run_isr;
   endproperty
   a_isr: assert property (p_isr) else $error("no isr");
   property p_noisr;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_q == sleep_wdt_pkg::ST_WAKE && !global_irq_enable |=> !o_run_isr;
   endproperty
   a_noisr: assert property (p_noisr) else $error("isr without gie");
   property p_back;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_q == sleep_wdt_pkg::ST_WAKE |=> st_q == sleep_wdt_pkg::ST_RUN;
   endproperty
   a_back: assert property (p_back) else $error("no run");
   property p_m10;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_watchdog_cfg_mode == sleep_wdt_pkg::MODE_NOSLEEP && asleep
      |=> cnt_q == '0;
   endproperty
   a_m10: assert property (p_m10) else $error("ran in sleep");
   property p_sw;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_watchdog_cfg_mode == sleep_wdt_pkg::MODE_SW && !swen_q
      |=> cnt_q == '0;
   endproperty
   a_sw: assert property (p_sw) else $error("sw off ran");
   property p_fail;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      i_osc_fail |=> cnt_q == '0;
   endproperty
   a_fail: assert property (p_fail) else $error("fail not cleared");
   property p_enter;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      s_sleep_take |=> cnt_q == '0;
   endproperty
   a_enter: assert property (p_enter) else $error("entry no clear");
   property p_inc;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      active && i_lfosc_tick && !clr && !expired
      |=> cnt_q == $past(cnt_q) + 1'b1;
   endproperty
   a_inc: assert property (p_inc) else $error("no count");
   property p_idle;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      !i_lfosc_tick && !clr |=> $stable(cnt_q);
   endproperty
   a_idle: assert property (p_idle) else $error("count moved");
   property p_wpulse;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      o_wake |=> !o_wake;
   endproperty
   a_wpulse: assert property (p_wpulse) else $error("long wake");
   property p_rpulse;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      o_wdt_reset |=> !o_wdt_reset;
   endproperty
   a_rpulse: assert property (p_rpulse) else $error("long reset");
   property p_rsv;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      ps_q > sleep_wdt_pkg::PS_MAX |-> ps_eff == sleep_wdt_pkg::PS_MIN;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved period");
   property p_keep;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      asleep && !expired |=> $stable(to_n_q) && $stable(pd_n_q);
   endproperty
   a_keep: assert property (p_keep) else $error("flags moved");
   property p_cflags;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      st_q == sleep_wdt_pkg::ST_RUN && i_watchdog_clear_instr &&
      !i_sleep_instr |=> to_n_q && pd_n_q;
   endproperty
   a_cflags: assert property (p_cflags) else $error("flags kept");
endmodule : sleep_wdt

// File: design/sleep_wdt_pkg.sv
// Package: register offsets, fields, reset values and timing for sleep/watchdog
package sleep_wdt_pkg;
   // Register map
   localparam logic [1:0] ADDR_INTCTL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_WDTCTL = 2'h2;
   // Field positions
   localparam int GIE_BIT = 7;
   localparam int TO_BIT = 4;
   localparam int PD_BIT = 3;
   localparam int SWEN_BIT = 0;
   localparam int PS_LSB = 1;
   localparam int PS_MSB = 5;
   // Reset values and period code limits
   localparam logic [4:0] PS_RESET = 5'h0B;
   localparam logic [4:0] PS_MAX = 5'h12;
   localparam logic [4:0] PS_MIN = 5'h00;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   // Watchdog modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SW = 2'h1;
   localparam logic [1:0] MODE_NOSLEEP = 2'h2;
   localparam logic [1:0] MODE_ON = 2'h3;
   // Counter: base 1:32 of low-frequency clock, longest 2^23
   localparam int CNT_W = 23;
   localparam int BASE_SHIFT = 5;
   // Core states
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE = 2'b11
   } core_state_t;
endpackage : sleep_wdt_pkg

// File: test/core_model.sv
// Core model: issues instruction pulses while its clock runs
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Requests and clock gate
   input wire logic i_sleep_req,
   input wire logic i_clr_req,
   input wire logic i_clk_en,
   // Instruction pulses
   output logic o_sleep_instr,
   output logic o_clr_instr
);
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sleep_instr <= 1'b0;
         o_clr_instr <= 1'b0;
      end else begin
         o_sleep_instr <= i_sleep_req & i_clk_en;
         o_clr_instr <= i_clr_req & i_clk_en;
      end
   end
endmodule : core_model

// File: test/sleep_wdt_tb.sv
// Testbench: sleep and watchdog block against a core model
`timescale 1ns/1ps
module sleep_wdt_tb;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0;
   logic irq = 1'b0, ofail = 1'b0, osc_startup_timer = 1'b0, sreq = 1'b0, creq = 1'b0;
   logic s_i, c_i, clk_en, hold, lf, wrst, wake, isr;
   logic [1:0] addr = 2'h0, mode = 2'h3;
   logic [7:0] wdata = 8'h00, rdata;
   logic [4:0] ps;
   int miscompares = 0, n_tests = 0, nr = 0, nw = 0, ni = 0, r0, w0, i0;
   always #12.5 clk = ~clk;
   always @(negedge clk) begin
      nr += wrst;
      nw += wake;
      ni += isr;
   end
   sleep_wdt sleep_wdt_inst (.i_core_clk(clk), .i_arst_n(rst_n),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .i_sleep_instr(s_i), .i_watchdog_clear_instr(c_i),
      .i_irq_pending(irq), .i_watchdog_cfg_mode(mode),
      .i_lfosc_tick(tick), .i_osc_fail(ofail),
      .i_osc_startup_timer_run(osc_startup_timer), .o_rdata(rdata),
      .o_cpu_clk_en(clk_en), .o_port_hold(hold), .o_lfosc_en(lf),
      .o_wdt_reset(wrst), .o_wake(wake), .o_run_isr(isr));
   core_model core_model_inst (.i_core_clk(clk), .i_arst_n(rst_n),
      .i_sleep_req(sreq), .i_clr_req(creq), .i_clk_en(clk_en),
      .o_sleep_instr(s_i), .o_clr_instr(c_i));
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic rst;
      #5 rst_n = 1'b0;
      cyc(2);
      #5 rst_n = 1'b1;
      cyc(1);
   endtask : rst
   task automatic bus(input logic w, input logic [1:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 if (!w) chk("rdata", d, rdata);
   endtask : bus
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
         cyc($urandom % 3);
      end
      cyc(3);
   endtask : ticks
   task automatic instr(input logic s);
      @(posedge clk);
      sreq <= s;
      creq <= !s;
      @(posedge clk);
      sreq <= 1'b0;
      creq <= 1'b0;
      cyc(3);
   endtask : instr
   task automatic snap;
      r0 = nr;
      w0 = nw;
      i0 = ni;
   endtask : snap
   task automatic cnt(input string nm, input int r, input int w,
                      input int i);
      chk(nm, 8'(r * 16 + w * 4 + i),
          8'((nr - r0) * 16 + (nw - w0) * 4 + (ni - i0)));
      $display("done %s", nm);
   endtask : cnt
   initial begin
      cyc(30000);
      miscompares++;
      test_done();
   end
   initial begin
      void'($urandom(32'h59D2));
      ps = 5'(19 + $urandom % 13);
      rst();
      snap();
      bus(0, 2'h0, 8'h00);
      bus(0, 2'h1, 8'h18);
      bus(0, 2'h2, 8'h16);
      bus(1, 2'h3, 8'hFF);
      bus(0, 2'h3, 8'h00);
      bus(1, 2'h1, 8'h00);
      bus(0, 2'h1, 8'h18);
      bus(1, 2'h0, 8'h80);
      bus(1, 2'h2, {2'h0, ps, 1'b0});
      bus(0, 2'h2, {2'h0, ps, 1'b0});
      ticks(31);
      cnt("no expiry", 0, 0, 0);
      ticks(1);
      cnt("expiry", 1, 0, 0);
      bus(0, 2'h1, 8'h08);
      instr(0);
      bus(0, 2'h1, 8'h18);
      ticks(31);
      instr(0);
      ticks(31);
      @(posedge clk) ofail <= 1'b1;
      @(posedge clk) ofail <= 1'b0;
      ticks(31);
      osc_startup_timer <= 1'b1;
      ticks(40);
      osc_startup_timer <= 1'b0;
      ticks(31);
      cnt("clears", 1, 0, 0);
      ticks(1);
      cnt("after clears", 2, 0, 0);
      instr(1);
      chk("clk_en", 8'h00, 8'(clk_en));
      chk("hold", 8'h01, 8'(hold));
      chk("lfosc", 8'h01, 8'(lf));
      bus(0, 2'h1, 8'h10);
      ticks(32);
      cnt("sleep expiry", 2, 1, 0);
      bus(0, 2'h1, 8'h00);
      irq <= 1'b1;
      instr(1);
      chk("noop clk_en", 8'h01, 8'(clk_en));
      bus(0, 2'h1, 8'h00);
      irq <= 1'b0;
      instr(0);
      mode <= 2'h2;
      instr(1);
      ticks(40);
      cnt("mode 10 sleep", 2, 1, 0);
      irq <= 1'b1;
      cyc(3);
      irq <= 1'b0;
      cnt("irq wake", 2, 2, 1);
      bus(0, 2'h1, 8'h10);
      mode <= 2'h3;
      ticks(31);
      cnt("after wake", 2, 2, 1);
      snap();
      mode <= 2'h0;
      ticks(40);
      mode <= 2'h1;
      ticks(40);
      cnt("off modes", 0, 0, 0);
      bus(1, 2'h2, 8'h01);
      ticks(32);
      cnt("sw mode", 1, 0, 0);
      bus(1, 2'h0, 8'h00);
      instr(1);
      irq <= 1'b1;
      cyc(3);
      irq <= 1'b0;
      cnt("global off", 1, 1, 0);
      instr(1);
      rst();
      chk("rst clk_en", 8'h01, 8'(clk_en));
      bus(0, 2'h1, 8'h18);
      bus(0, 2'h2, 8'h16);
      test_done();
   end
endmodule : sleep_wdt_tb
